// ==== bus_target_model.sv ====
// far side of the bus: targets that acknowledge the broadcast address
// assumes the master drives the data pad through sda_out and sda_oe
`timescale 1ns/1ps
`default_nettype none
module bus_target_model (
   input  wire logic core_clk,  // bench clock, only paces the floating pattern
   input  wire logic sda_out,   // master data drive
   input  wire logic sda_oe,    // master data enable
   input  wire logic pullup_en, // master weak pull-up
   input  wire logic ack_en,    // targets answer when high
   output logic      sda_line   // resolved data wire
);
   logic float_lvl = 1'b0;

   // undriven wire wanders so a stale value never reads as valid
   always @(posedge core_clk) float_lvl <= ~float_lvl;

   // targets hold data low while the master has released it with pull-up
   assign sda_line = sda_oe ? sda_out : (ack_en && pullup_en) ? 1'b0
                   : pullup_en ? 1'b1 : float_lvl;
endmodule : bus_target_model
`default_nettype wire

// ==== hdr_entry_pkg.sv ====
// package for the high data rate entry codec: bus constants, timing, types
// assumes a 200 MHz core clock and a single master on the two-wire bus
package hdr_entry_pkg;

   // timing
   localparam int CLK_PERIOD_NS   = 5;
   localparam int SCL_HIGH_MAX_NS = 50;
   // high phase must stay strictly below the limit: round down after minus one
   localparam int SCL_HIGH_MAX_CYC = (SCL_HIGH_MAX_NS - 1) / CLK_PERIOD_NS;
   // one bus step; a single-rate high phase spans two steps
   localparam int SCL_STEP_CYC     = SCL_HIGH_MAX_CYC / 2;

   // entry sequence
   localparam logic [6:0] BCAST_ADDR               = 7'h7E;
   localparam logic       DIR_WRITE                = 1'h0;
   localparam logic [7:0] enter_double_rate_cmd    = 8'h20;
   localparam logic [7:0] enter_pure_ternary_cmd   = 8'h21;
   localparam logic [7:0] enter_legacy_ternary_cmd = 8'h22;

   // frame layout
   localparam int         ADDR_BITS     = 8;
   localparam int         CMD_BITS      = 9;
   localparam int         DDR_WORD_BITS = 20;
   localparam int         CRC_BITS      = 5;
   localparam int         TERN_SYMS     = 12;
   localparam logic [1:0] DDR_PREAMBLE  = 2'h2;
   localparam logic [4:0] CRC5_POLY     = 5'h05;
   localparam logic [4:0] CRC5_INIT     = 5'h1F;

   typedef enum logic [1:0] {
      single_rate_mode,
      double_rate_mode,
      legacy_ternary_mode,
      pure_ternary_mode
   } bus_mode_t;

   // everything the master drives onto the bus
   typedef struct packed {
      logic scl;
      logic scl_oe;
      logic sda;
      logic sda_oe;
      logic pullup_en;
   } bus_pins_t;

endpackage : hdr_entry_pkg

// ==== hdr_mode_entry_codec.sv ====
// bus master that enters a high data rate mode and frames words in it
// assumes word source on core_clk; sda_in arrives asynchronously from the pad
//
// Operation
// - from bus free, start by pulling data low while clock stays high
// - then send broadcast address 7E and a write direction bit
// - for the acknowledge, release data to open drain with pull-up on
// - command 20 with parity 0 enters double rate mode at once
// - command 22 with parity 1 enters legacy ternary mode
// - command 21 with parity 1 enters pure ternary mode
// - double rate data is sampled on both clock edges
// - double rate word: two-bit preamble, two bytes, two parity bits
// - double rate traffic ends with a five-bit CRC after the words
// - outside pure ternary, every clock high phase is below 50 ns
// - legacy ternary chosen only when a legacy device is present
// - pure ternary chosen only without legacy devices; long highs allowed
// - legacy ternary inserts dataless clock falls to keep highs short
// - in legacy ternary a clock fall without data change is a dummy, never a symbol
// - each octal digit becomes two ternary symbols carried by transitions
// - a symbol is any change of clock, data, or both together
`timescale 1ns/1ps
`default_nettype none
module hdr_mode_entry_codec
   import hdr_entry_pkg::*;
#(
   parameter int unsigned STEP_CYC = SCL_STEP_CYC
) (
   input  wire logic        core_clk,       // 200 MHz system clock
   input  wire logic        rst_n,          // async reset, active low
   input  wire logic        clk_en,         // freezes all state while low
   input  wire logic        enter_req,      // pulse: start mode entry
   input  wire logic        ternary_sel,    // 1 ternary, 0 double rate
   input  wire logic        legacy_present, // a legacy device sits on the bus
   input  wire logic        word_valid,     // word offered
   input  wire logic [15:0] word_data,      // word payload
   input  wire logic        word_last,      // offered word ends the traffic
   output logic             word_ready,     // word taken when valid too
   input  wire logic        sda_in,         // data pad level
   output logic             scl_out,        // clock pad drive
   output logic             scl_oe,         // clock pad enable
   output logic             sda_out,        // data pad drive
   output logic             sda_oe,         // data pad enable
   output logic             pullup_en,      // weak pull-up on data
   output bus_mode_t        bus_mode,       // current signalling mode
   output logic             busy,           // sequence in progress
   output logic             ack_error       // entry address not acknowledged
);

   localparam int SW = (STEP_CYC < 2) ? 1 : $clog2(STEP_CYC);

   // the step must keep a two-step high phase below the legacy filter limit
   if (STEP_CYC < 2 || 2 * STEP_CYC > SCL_HIGH_MAX_CYC) begin : g_bad_step
      $error("STEP_CYC out of range");
   end

   typedef enum logic [3:0] {
      st_idle, st_start, st_addr, st_ack, st_cmd,
      st_word_wait, st_ddr, st_crc, st_tern, st_done
   } state_t;

   state_t      state, next_state;
   logic [1:0]  sub, next_sub;
   logic [4:0]  cnt, next_cnt;
   logic [23:0] sr, next_sr;
   logic [4:0]  crc, next_crc;
   logic        last, next_last;
   bus_pins_t   pins, next_pins;
   bus_mode_t   next_mode, target, next_target;
   logic        next_ready, next_busy, next_ack_err;
   logic [SW-1:0] step, next_step;
   logic        tick;
   logic        sda_s1, sda_s2, sda_s3, sda_seen;

   // serial crc over one data word, msb first
   function automatic logic [4:0] crc5(input logic [4:0] c, input logic [15:0] d);
      logic [4:0] r;
      logic       fb;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         fb = r[4] ^ d[i];
         r = {r[3:0], 1'b0} ^ (fb ? CRC5_POLY : 5'h00);
      end
      return r;
   endfunction : crc5

   // parity over odd and even bit positions of the word
   function automatic logic [1:0] ddr_par(input logic [15:0] d);
      logic a;
      logic b;
      a = 1'b0;
      b = 1'b0;
      for (int i = 0; i < 8; i++) begin
         a ^= d[2*i+1];
         b ^= d[2*i];
      end
      return {a, ~b};
   endfunction : ddr_par

   // six octal digits, each split into two ternary symbols, msb first
   function automatic logic [23:0] tern_pack(input logic [15:0] d);
      logic [17:0] v;
      logic [23:0] r;
      v = {2'h0, d};
      r = 24'h000000;
      for (int k = 0; k < 6; k++) begin
         case (v[17-3*k -: 3])
            3'h0:    r[23-4*k -: 4] = 4'h0;
            3'h1:    r[23-4*k -: 4] = 4'h1;
            3'h2:    r[23-4*k -: 4] = 4'h2;
            3'h3:    r[23-4*k -: 4] = 4'h4;
            3'h4:    r[23-4*k -: 4] = 4'h5;
            3'h5:    r[23-4*k -: 4] = 4'h6;
            3'h6:    r[23-4*k -: 4] = 4'h8;
            default: r[23-4*k -: 4] = 4'h9;
         endcase
      end
      return r;
   endfunction : tern_pack

   // entry command for the chosen mode, parity bit appended
   function automatic logic [8:0] entry_cmd(input bus_mode_t m);
      logic [7:0] c;
      case (m)
         legacy_ternary_mode: c = enter_legacy_ternary_cmd;
         pure_ternary_mode:   c = enter_pure_ternary_cmd;
         default:             c = enter_double_rate_cmd;
      endcase
      return {c, ~^c};
   endfunction : entry_cmd

   // data pad: three stages, a change counts once stages two and three agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_s1   <= 1'b1;
         sda_s2   <= 1'b1;
         sda_s3   <= 1'b1;
         sda_seen <= 1'b1;
      end else if (clk_en) begin
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         if (sda_s2 == sda_s3) begin
            sda_seen <= sda_s3;
         end
      end
   end

   // step timer paces every bus transition outside the idle state, whose levels are driven at once
   always_comb begin
      tick      = clk_en && (step == SW'(STEP_CYC - 1));
      next_step = step;
      if (clk_en) begin
         next_step = tick ? '0 : SW'(step + 1'b1);
      end
   end

   // sequencer: entry handshake, then word framing in the chosen mode
   always_comb begin
      next_state   = state;
      next_sub     = sub;
      next_cnt     = cnt;
      next_sr      = sr;
      next_crc     = crc;
      next_last    = last;
      next_pins    = pins;
      next_mode    = bus_mode;
      next_target  = target;
      next_ready   = word_ready;
      next_ack_err = ack_error;
      if (clk_en) begin
         next_ready = 1'b0;
         case (state)
            st_idle: begin
               // the clock rests high only while the bus is in single rate
               next_pins.scl       = (bus_mode == single_rate_mode);
               next_pins.scl_oe    = 1'b1;
               next_pins.sda       = 1'b1;
               next_pins.sda_oe    = 1'b1;
               next_pins.pullup_en = 1'b0;
               if (enter_req) begin
                  next_state   = st_start;
                  next_sub     = 2'h0;
                  next_ack_err = 1'b0;
                  next_mode    = single_rate_mode;
                  if (!ternary_sel) begin
                     next_target = double_rate_mode;
                  end else if (legacy_present) begin
                     next_target = legacy_ternary_mode;
                  end else begin
                     next_target = pure_ternary_mode;
                  end
               end
            end
            st_start: if (tick) begin
               if (sub == 2'h0 && !pins.scl) begin
                  // a high rate mode left the clock low: free the bus first
                  next_pins.scl = 1'b1;
               end else if (sub == 2'h0) begin
                  next_pins.sda = 1'b0;
                  next_sub      = 2'h1;
               end else begin
                  next_state = st_addr;
                  next_sr    = {BCAST_ADDR, DIR_WRITE, 16'h0000};
                  next_cnt   = 5'(ADDR_BITS);
                  next_sub   = 2'h0;
               end
            end
            st_addr, st_cmd: if (tick) begin
               // four steps a bit: clock low, data, clock high, hold
               next_sub = sub + 2'h1;
               case (sub)
                  2'h0: next_pins.scl = 1'b0;
                  2'h1: begin
                     next_pins.sda       = sr[23];
                     next_pins.sda_oe    = 1'b1;
                     next_pins.pullup_en = 1'b0;
                  end
                  2'h2: next_pins.scl = 1'b1;
                  default: begin
                     next_sr  = sr << 1;
                     next_cnt = cnt - 5'h1;
                     if (cnt == 5'h1) begin
                        if (state == st_addr) begin
                           next_state = st_ack;
                        end else begin
                           // new mode holds from the end of the parity bit
                           next_pins.scl = 1'b0;
                           next_mode     = target;
                           next_crc      = CRC5_INIT;
                           next_state    = st_word_wait;
                        end
                     end
                  end
               endcase
            end
            st_ack: if (tick) begin
               next_sub = sub + 2'h1;
               case (sub)
                  2'h0: next_pins.scl = 1'b0;
                  2'h1: begin
                     next_pins.sda_oe    = 1'b0;
                     next_pins.pullup_en = 1'b1;
                  end
                  2'h2: next_pins.scl = 1'b1;
                  default: begin
                     if (!sda_seen) begin
                        next_state = st_cmd;
                        next_sr    = {entry_cmd(target), 15'h0000};
                        next_cnt   = 5'(CMD_BITS);
                     end else begin
                        next_ack_err = 1'b1;
                        next_state   = st_idle;
                     end
                  end
               endcase
            end
            st_word_wait: begin
               next_pins.sda_oe    = 1'b1;
               next_pins.pullup_en = 1'b0;
               next_ready          = 1'b1;
               if (word_ready && word_valid) begin
                  next_ready = 1'b0;
                  next_last  = word_last;
                  next_sub   = 2'h0;
                  if (bus_mode == double_rate_mode) begin
                     next_sr    = {DDR_PREAMBLE, word_data, ddr_par(word_data), 4'h0};
                     next_cnt   = 5'(DDR_WORD_BITS);
                     next_crc   = crc5(crc, word_data);
                     next_state = st_ddr;
                  end else begin
                     next_sr    = tern_pack(word_data);
                     next_cnt   = 5'(TERN_SYMS);
                     next_state = st_tern;
                  end
               end
            end
            st_ddr, st_crc: if (tick) begin
               // data settles one step before each clock edge, either way
               if (sub == 2'h0) begin
                  next_pins.sda = sr[23];
                  next_sub      = 2'h1;
               end else begin
                  next_pins.scl = ~pins.scl;
                  next_sr       = sr << 1;
                  next_cnt      = cnt - 5'h1;
                  next_sub      = 2'h0;
                  if (cnt == 5'h1) begin
                     if (state == st_ddr && last) begin
                        next_state = st_crc;
                        next_sr    = {crc, 19'h00000};
                        next_cnt   = 5'(CRC_BITS);
                     end else begin
                        next_state = st_done;
                     end
                  end
               end
            end
            st_tern: if (tick) begin
               if (bus_mode == legacy_ternary_mode && pins.scl) begin
                  // dataless fall keeps the high phase one step long
                  next_pins.scl = 1'b0;
               end else begin
                  case (sr[23:22])
                     2'h1: next_pins.sda = ~pins.sda;
                     2'h2: begin
                        next_pins.scl = ~pins.scl;
                        next_pins.sda = ~pins.sda;
                     end
                     default: next_pins.scl = ~pins.scl;
                  endcase
                  next_sr  = sr << 2;
                  next_cnt = cnt - 5'h1;
                  if (cnt == 5'h1) begin
                     next_state = st_done;
                  end
               end
            end
            st_done: if (tick) begin
               next_pins.scl = 1'b0;
               next_state    = last ? st_idle : st_word_wait;
            end
            default: next_state = st_idle;
         endcase
      end
      next_busy = (next_state != st_idle);
   end

   // sequencer registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= st_idle;
         sub        <= 2'h0;
         cnt        <= 5'h00;
         sr         <= 24'h000000;
         crc        <= 5'h00;
         last       <= 1'b0;
         pins       <= 5'h14;
         bus_mode   <= single_rate_mode;
         target     <= double_rate_mode;
         word_ready <= 1'b0;
         busy       <= 1'b0;
         ack_error  <= 1'b0;
         step       <= '0;
      end else begin
         state      <= next_state;
         sub        <= next_sub;
         cnt        <= next_cnt;
         sr         <= next_sr;
         crc        <= next_crc;
         last       <= next_last;
         pins       <= next_pins;
         bus_mode   <= next_mode;
         target     <= next_target;
         word_ready <= next_ready;
         busy       <= next_busy;
         ack_error  <= next_ack_err;
         step       <= next_step;
      end
   end

   assign scl_out   = pins.scl;
   assign scl_oe    = pins.scl_oe;
   assign sda_out   = pins.sda;
   assign sda_oe    = pins.sda_oe;
   assign pullup_en = pins.pullup_en;

   // checking aid: bits seen on the pads at clock rise, and high phase length
   logic [8:0] sent;
   logic [7:0] high_cnt;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sent     <= 9'h000;
         high_cnt <= 8'h00;
      end else if (clk_en) begin
         if (state == st_start || state == st_ack) begin
            sent <= 9'h000;
         end else if (!pins.scl && next_pins.scl) begin
            sent <= {sent[7:0], pins.sda};
         end
         // the clock rests high over the start: a bus-free level, not a pulse
         if (pins.scl && state != st_idle && state != st_start) begin
            high_cnt <= (high_cnt == 8'hFF) ? high_cnt : high_cnt + 8'h01;
         end else begin
            high_cnt <= 8'h00;
         end
      end
   end

   chk_start_cond: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_start && sub == 2'h0 && tick && pins.scl && pins.sda) |=> (!pins.sda && pins.scl))
      else $error("start not formed with clock high");
   chk_addr_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_addr && next_state == st_ack) |=> sent[7:0] == {BCAST_ADDR, DIR_WRITE})
      else $error("broadcast address byte wrong");
   chk_ack_release: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_ack && sub == 2'h2 && tick) |=> (!pins.sda_oe && pins.pullup_en)[*2])
      else $error("data not released for acknowledge");
   chk_ddr_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_cmd && next_mode == double_rate_mode && bus_mode != next_mode)
      |=> sent == {enter_double_rate_cmd, 1'b0} && state == st_word_wait)
      else $error("double rate entry code wrong");
   chk_legacy_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(bus_mode == legacy_ternary_mode) |-> sent == {enter_legacy_ternary_cmd, 1'b1})
      else $error("legacy ternary entry code wrong");
   chk_pure_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(bus_mode == pure_ternary_mode) |-> sent == {enter_pure_ternary_cmd, 1'b1})
      else $error("pure ternary entry code wrong");
   chk_ddr_edges: assert property (@(posedge core_clk) disable iff (!rst_n)
      ((state == st_ddr || state == st_crc) && $changed(pins.sda)) |-> $stable(pins.scl))
      else $error("data moved on a clock edge");
   chk_ddr_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_word_wait && next_state == st_ddr)
      |=> sr[23:22] == DDR_PREAMBLE && cnt == 5'(DDR_WORD_BITS))
      else $error("double rate word not framed");
   chk_crc_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_ddr && next_state == st_crc) |=> cnt == 5'(CRC_BITS) && sr[23:19] == crc)
      else $error("crc field missing");
   chk_scl_short: assert property (@(posedge core_clk) disable iff (!rst_n)
      (bus_mode != pure_ternary_mode) |-> high_cnt <= 8'(SCL_HIGH_MAX_CYC))
      else $error("clock high phase too long");
   chk_legacy_choice: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_idle && enter_req && clk_en && ternary_sel && legacy_present)
      |=> target == legacy_ternary_mode)
      else $error("legacy ternary not chosen");
   chk_pure_choice: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == st_idle && enter_req && clk_en && ternary_sel && !legacy_present)
      |=> target == pure_ternary_mode)
      else $error("pure ternary not chosen");
   chk_dummy_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
      (bus_mode == legacy_ternary_mode && state == st_tern && $fell(pins.scl)
       && $stable(pins.sda)) |-> $stable(cnt))
      else $error("dummy fall consumed a symbol");
   chk_symbol_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state != st_word_wait && $past(state) == st_tern && $changed(cnt))
      |-> ($changed(pins.scl) || $changed(pins.sda)))
      else $error("symbol without transition");

endmodule : hdr_mode_entry_codec
`default_nettype wire

// ==== test_hdr_mode_entry_codec.sv ====
// self-checking bench: mode entry for all three commands, words in each mode
// assumes the codec runs with its default step of four core clocks
`timescale 1ns/1ps
`default_nettype none
module test_hdr_mode_entry_codec;
   import hdr_entry_pkg::*;
   localparam int LIMIT = 2000;
   logic core_clk = 0, rst_n = 0, clk_en = 1, enter_req = 0, ternary_sel = 0;
   logic legacy_present = 0, word_valid = 0, word_last = 0, ack_en = 1;
   logic [15:0] word_data = 16'h0000;
   logic        word_ready, scl_out, scl_oe, sda_out, sda_oe, pullup_en, busy, ack_error;
   logic        sda_line, scl_d, sda_d, start_seen;
   bus_mode_t   bus_mode, mode_d, cur_mode;
   logic [2:0]  q[$];
   logic [4:0]  crc;
   int          err_count = 0, num_checks = 0, hi = 0;

   initial forever #2.5 core_clk = ~core_clk;

   hdr_mode_entry_codec #(.STEP_CYC(4)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .enter_req(enter_req), .ternary_sel(ternary_sel),
      .legacy_present(legacy_present), .word_valid(word_valid), .word_data(word_data),
      .word_last(word_last), .word_ready(word_ready), .sda_in(sda_line), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe), .pullup_en(pullup_en),
      .bus_mode(bus_mode), .busy(busy), .ack_error(ack_error));
   bus_target_model partner (.core_clk(core_clk), .sda_out(sda_out), .sda_oe(sda_oe),
      .pullup_en(pullup_en), .ack_en(ack_en), .sda_line(sda_line));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   // bus monitor: mode of the previous sample decides how edges are read,
   // because the mode flips on the same edge as the closing clock fall
   always @(posedge core_clk) begin
      if (word_valid && word_ready) q.delete();
      if (enter_req) begin
         q.delete();
         start_seen = 0;
      end
      if (busy && scl_out && scl_d && sda_d && !sda_line && q.size() == 0) start_seen = 1;
      if (mode_d == single_rate_mode) begin
         // a clock rise before the start only frees the bus, no bit
         if (scl_out && !scl_d && start_seen) q.push_back({sda_oe, pullup_en, sda_line});
      end else if (mode_d == double_rate_mode) begin
         if (scl_out != scl_d) q.push_back({2'b00, sda_out});
      end else if ((scl_out != scl_d) || (sda_out != sda_d)) begin
         // a lone clock fall is a dummy in legacy ternary
         if (!(mode_d == legacy_ternary_mode && scl_d && !scl_out && sda_out == sda_d))
            q.push_back(sda_out == sda_d ? 3'h0 : scl_out == scl_d ? 3'h1 : 3'h2);
      end
      if (scl_d && !scl_out && busy && mode_d != pure_ternary_mode)
         check(hi <= SCL_HIGH_MAX_CYC, 1, "scl high phase");
      hi = (scl_out && start_seen) ? hi + 1 : 0;
      scl_d = scl_out;
      sda_d = sda_line;
      mode_d = bus_mode;
   end

   task automatic wait_ready();
      int n;
      for (n = 0; n < LIMIT && !(word_ready || !busy); n++) @(posedge core_clk);
      if (n == LIMIT) err_count++;
      #1;
   endtask : wait_ready

   task automatic enter(input logic t, input logic l, input logic a);
      logic [7:0] ab;
      logic [8:0] cb;
      logic [2:0] e;
      ab = {BCAST_ADDR, DIR_WRITE};
      cb[8:1] = !t ? enter_double_rate_cmd : l ? enter_legacy_ternary_cmd
              : enter_pure_ternary_cmd;
      cb[0] = ~^cb[8:1];
      cur_mode = !t ? double_rate_mode : l ? legacy_ternary_mode : pure_ternary_mode;
      crc = CRC5_INIT;
      @(posedge core_clk);
      #1 {ternary_sel, legacy_present, ack_en, enter_req} = {t, l, a, 1'b1};
      @(posedge core_clk);
      #1 enter_req = 0;
      wait_ready();
      repeat (2) @(posedge core_clk);
      #1 check(start_seen, 1, "start");
      check(scl_oe, 1, "scl drive");
      check(q.size(), a ? 18 : 9, "entry bits");
      for (int i = 0; i < (a ? 18 : 9); i++) begin
         e = i < 8 ? {2'b10, ab[7 - i]} : i == 8 ? {2'b01, !a} : {2'b10, cb[17 - i]};
         check(q[i], e, "entry bit");
      end
      check(ack_error, !a, "ack error");
      check(bus_mode, a ? cur_mode : single_rate_mode, "mode");
   endtask : enter

   task automatic word(input logic [15:0] d, input logic last);
      logic [19:0] w;
      logic [17:0] v;
      logic [2:0]  dg;
      int          n;
      w = {DDR_PREAMBLE, d, ^(d & 16'hAAAA), ~^(d & 16'h5555)};
      v = {2'b00, d};
      {word_data, word_last, word_valid} = {d, last, 1'b1};
      for (n = 0; n < LIMIT && !word_ready; n++) @(posedge core_clk);
      if (n == LIMIT) err_count++;
      @(posedge core_clk);
      #1 word_valid = 0;
      wait_ready();
      repeat (4) @(posedge core_clk);
      #1;
      if (cur_mode == double_rate_mode) begin
         for (int i = 0; i < 20; i++) check(q[i], w[19 - i], "ddr bit");
         for (int i = 15; i >= 0; i--)
            crc = {crc[3:0], 1'b0} ^ ((crc[4] ^ d[i]) ? CRC5_POLY : 5'h00);
         if (last) for (int i = 0; i < 5; i++) check(q[20 + i], crc[4 - i], "crc bit");
      end else begin
         for (int k = 0; k < 6; k++) begin
            dg = v[17 - 3 * k -: 3];
            check({q[2 * k], q[2 * k + 1]}, {dg / 3'h3, dg % 3'h3}, "symbols");
         end
      end
   endtask : word

   // four entries: double rate, legacy ternary, pure ternary, unanswered
   initial begin
      void'($urandom(152));
      repeat (16) @(posedge core_clk);
      #1 rst_n = 1;
      for (int m = 0; m < 4; m++) begin
         enter(m == 1 || m == 2, m == 1 ? 1'b1 : m == 2 ? 1'b0 : 1'($urandom), m != 3);
         if (m != 3) for (int k = 0; k < 3; k++) word(k == 0 ? 16'hFFFF : 16'($urandom), k == 2);
      end
      wrap_up();
   end

   // hang guard sized well above the expected few thousand cycles
   initial begin
      #300000;
      err_count++;
      wrap_up();
   end
endmodule : test_hdr_mode_entry_codec
`default_nettype wire
